/* rtl/lcm_regs.vh */
// command encodings, mode-register fields and timing counts for the command decoder
`ifndef LCM_REGS_VH
`define LCM_REGS_VH
// ==========================================
// command encodings {cs_n, ras_n, cas_n, we_n}
`define LCM_CMD_LOAD 4'h0
`define LCM_CMD_REFRESH 4'h1
`define LCM_CMD_PRECHARGE 4'h2
`define LCM_CMD_ACTIVATE 4'h3
`define LCM_CMD_WRITE 4'h4
`define LCM_CMD_READ 4'h5
`define LCM_CMD_TERMINATE 4'h6
`define LCM_CMD_NOP 4'h7
// ==========================================
// mode register fields
`define LCM_MR_BL_LSB 0
`define LCM_MR_BL_MSB 2
`define LCM_MR_BT_BIT 3
`define LCM_MR_CL_LSB 4
`define LCM_MR_CL_MSB 6
`define LCM_EMR_DS_LSB 5
`define LCM_EMR_DS_MSB 7
`define LCM_AP_BIT 10
// burst length codes
`define LCM_BL_2 3'h1
`define LCM_BL_4 3'h2
`define LCM_BL_8 3'h3
`define LCM_BL_16 3'h4
`define LCM_BL_FULL 3'h7
`define LCM_FULL_PAGE_LEN 9'h100
// ==========================================
// timing
`define LCM_CLK_PERIOD_NS 100
`define LCM_MRD_CLKS 2
`define LCM_XSR_NS 120
`define LCM_XP_NS 25
`define LCM_RFC_NS 72
`endif

/* rtl/lcm_fifo.v */
// parameterised valid/ready fifo for masked write data
`timescale 1ns/100ps
`default_nettype none
module lcm_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 8,
  parameter AW = 3
)(
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
  reg [AW-1:0] wr_ff; // write pointer
  reg [AW-1:0] rd_ff; // read pointer
  reg [AW:0] cnt_ff; // fill level
  wire push;
  wire pop;
  assign in_ready_o = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  // ==========================================
  // pointers and level
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ff <= {AW{1'b0}};
      rd_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ff <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
      if (pop)
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
      if (push & ~pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop & ~push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
  // ==========================================
  // storage has no reset, data only
  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ff] <= in_data_i;
  end
endmodule // lcm_fifo
`default_nettype wire

/* rtl/lcm_top.v */
// command decoder, mode registers and power states of a four-bank low-power ddr memory
// Contract
// - all-low command with banks zero loads mode
// - two clocks before next command after load
// - two bank bits select banks A-D
// - auto-precharge bit precharges all banks (on a read or write the code closes only the burst's bank)
// - burst terminate accepted at every length
// - mask bit high discards write byte
// - mode register undefined until programmed
// - fields: burst length, type, read latency
// - full page burst is 256 columns
// - auto-refresh precharges internally
// - burst order sequential wrap or interleaved
// - extended load sets drive strength
`timescale 1ns/100ps
`default_nettype none
`include "lcm_regs.vh"
module lcm_top #(
  parameter NBANK = 4,
  parameter DQW = 32
)(
  // clock and reset
  input wire CLOCK_I,
  input wire RST_N_I,
  // command and address
  input wire CKE_I,
  input wire CS_N_I,
  input wire RAS_N_I,
  input wire CAS_N_I,
  input wire WE_N_I,
  input wire [1:0] BANK_SELECT_BITS_I,
  input wire [10:0] ADDR_I,
  // write data, already sampled on strobe edges
  input wire WDATA_VALID_I,
  input wire [DQW-1:0] WDATA_I,
  input wire [DQW/8-1:0] WRITE_BYTE_MASK_I,
  output wire WDATA_READY_O,
  // write data to the array
  output wire ARR_VALID_O,
  input wire ARR_READY_I,
  output wire [DQW-1:0] ARR_DATA_O,
  output wire [DQW/8-1:0] ARR_BYTE_EN_O,
  output reg [1:0] ARR_BANK_O,
  output reg [7:0] ARR_COL_O,
  // status
  output reg [NBANK-1:0] BANK_OPEN_O,
  output reg MODE_VALID_O,
  output reg [2:0] BURST_LEN_CODE_O,
  output reg BURST_INTERLEAVED_O,
  output reg [2:0] READ_LATENCY_O,
  output reg [2:0] DRIVE_STRENGTH_O,
  output reg BURST_ACTIVE_O,
  output reg BUSY_O,
  output reg CMD_ILLEGAL_O,
  output reg [2:0] POWER_STATE_O
);
  // ==========================================
  // power states
  localparam ST_IDLE = 3'h0;
  localparam ST_SELF_REFRESH = 3'h1;
  localparam ST_POWER_DOWN = 3'h2;
  localparam ST_DEEP_POWER_DOWN = 3'h3;
  localparam ST_EXIT = 3'h4;
  // derived counts, rounded up, at least one cycle
  localparam MRD_CLKS = `LCM_MRD_CLKS;
  localparam XSR_CLKS = (`LCM_XSR_NS + `LCM_CLK_PERIOD_NS - 1) / `LCM_CLK_PERIOD_NS;
  localparam XP_CLKS = (`LCM_XP_NS + `LCM_CLK_PERIOD_NS - 1) / `LCM_CLK_PERIOD_NS;
  localparam RFC_CLKS = (`LCM_RFC_NS + `LCM_CLK_PERIOD_NS - 1) / `LCM_CLK_PERIOD_NS;
  // self-refresh exit needs at least two pulses whatever the rate
  localparam XSR_USE = (XSR_CLKS < 2) ? 2 : XSR_CLKS;
  // ==========================================
  // decoding used in several places
  function [3:0] bank_onehot;
    input [1:0] sel;
    begin
      bank_onehot = 4'h1 << sel;
    end
  endfunction
  // burst length in beats from the code
  function [8:0] burst_beats;
    input [2:0] code;
    begin
      case (code)
        `LCM_BL_2: burst_beats = 9'h002;
        `LCM_BL_4: burst_beats = 9'h004;
        `LCM_BL_8: burst_beats = 9'h008;
        `LCM_BL_16: burst_beats = 9'h010;
        `LCM_BL_FULL: burst_beats = `LCM_FULL_PAGE_LEN;
        default: burst_beats = 9'h002;
      endcase
    end
  endfunction
  // ==========================================
  // command capture
  reg cke_prev_ff; // clock enable of the previous edge
  wire [3:0] cmd;
  wire cmd_sel;
  assign cmd = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
  assign cmd_sel = ~CS_N_I;
  wire nop_or_desel;
  assign nop_or_desel = CS_N_I | (cmd == `LCM_CMD_NOP);
  reg [2:0] pstate_ff; // power state
  reg [3:0] wait_ff; // busy window counter
  reg [8:0] beat_ff; // beats left in burst
  reg [8:0] idx_ff; // beat index
  reg [7:0] start_ff; // burst start column
  reg is_wr_ff; // active burst is a write
  reg ap_ff; // auto-precharge pending
  wire normal;
  assign normal = (pstate_ff == ST_IDLE) & cke_prev_ff & (wait_ff == 4'h0);
  wire do_cmd;
  assign do_cmd = normal & CKE_I & cmd_sel;
  // column of the current beat, sequential wrap or interleaved
  reg [7:0] cur_col;
  reg [8:0] len;
  reg [7:0] mask;
  always @*
  begin
    len = burst_beats(BURST_LEN_CODE_O);
    mask = len[7:0] - 8'h01;
    if (BURST_INTERLEAVED_O && BURST_LEN_CODE_O != `LCM_BL_FULL)
      cur_col = (start_ff & ~mask) | ((start_ff ^ idx_ff[7:0]) & mask);
    else
      cur_col = (start_ff & ~mask) | ((start_ff + idx_ff[7:0]) & mask);
  end
  // ==========================================
  // write path buffer; masked bytes are turned into disabled lanes
  wire fifo_valid;
  wire fifo_ready;
  wire [DQW+DQW/8-1:0] fifo_out;
  assign fifo_ready = ARR_READY_I;
  assign ARR_VALID_O = fifo_valid;
  assign ARR_DATA_O = fifo_out[DQW-1:0];
  assign ARR_BYTE_EN_O = fifo_out[DQW+DQW/8-1:DQW];
  wire accept_beat;
  // data arriving outside a write burst is ignored
  assign accept_beat = WDATA_VALID_I & BURST_ACTIVE_O & is_wr_ff & WDATA_READY_O;
  lcm_fifo #(
    .WIDTH(DQW + DQW/8),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .clk_i(CLOCK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(WDATA_VALID_I & BURST_ACTIVE_O & is_wr_ff),
    .in_ready_o(WDATA_READY_O),
    .in_data_i({~WRITE_BYTE_MASK_I, WDATA_I}),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_out)
  );
  // ==========================================
  // main sequencer
  always @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      cke_prev_ff <= 1'b0;
      pstate_ff <= ST_IDLE;
      wait_ff <= 4'h0;
      beat_ff <= 9'h000;
      idx_ff <= 9'h000;
      start_ff <= 8'h00;
      is_wr_ff <= 1'b0;
      ap_ff <= 1'b0;
      BANK_OPEN_O <= {NBANK{1'b0}};
      MODE_VALID_O <= 1'b0;
      BURST_LEN_CODE_O <= 3'h0;
      BURST_INTERLEAVED_O <= 1'b0;
      READ_LATENCY_O <= 3'h0;
      DRIVE_STRENGTH_O <= 3'h0;
      BURST_ACTIVE_O <= 1'b0;
      BUSY_O <= 1'b0;
      CMD_ILLEGAL_O <= 1'b0;
      POWER_STATE_O <= ST_IDLE;
      ARR_BANK_O <= 2'h0;
      ARR_COL_O <= 8'h00;
    end
    else
    begin
      cke_prev_ff <= CKE_I;
      CMD_ILLEGAL_O <= 1'b0;
      if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
      // busy tracks the wait still pending after this edge; loads below override it
      BUSY_O <= (wait_ff > 4'h1);
      // burst progress: writes advance per accepted beat, reads per clock
      if (BURST_ACTIVE_O && (!is_wr_ff || accept_beat))
      begin
        ARR_COL_O <= cur_col;
        idx_ff <= idx_ff + 9'h001;
        if (beat_ff == 9'h001)
        begin
          BURST_ACTIVE_O <= 1'b0;
          if (ap_ff)
            BANK_OPEN_O <= BANK_OPEN_O & ~bank_onehot(ARR_BANK_O);
        end
        beat_ff <= beat_ff - 9'h001;
      end
      case (pstate_ff)
        ST_IDLE:
        begin
          if (normal && !CKE_I)
          begin
            // clock enable falling selects the low-power mode
            if (cmd == `LCM_CMD_REFRESH)
              pstate_ff <= ST_SELF_REFRESH;
            else if (cmd == `LCM_CMD_TERMINATE)
              pstate_ff <= ST_DEEP_POWER_DOWN;
            else if (nop_or_desel)
              pstate_ff <= ST_POWER_DOWN;
            else
              CMD_ILLEGAL_O <= 1'b1;
          end
          else if (do_cmd)
          begin
            case (cmd)
              `LCM_CMD_LOAD:
              begin
                if (BANK_SELECT_BITS_I == 2'h0)
                begin
                  BURST_LEN_CODE_O <= ADDR_I[`LCM_MR_BL_MSB:`LCM_MR_BL_LSB];
                  BURST_INTERLEAVED_O <= ADDR_I[`LCM_MR_BT_BIT];
                  READ_LATENCY_O <= ADDR_I[`LCM_MR_CL_MSB:`LCM_MR_CL_LSB];
                  MODE_VALID_O <= 1'b1;
                end
                else if (BANK_SELECT_BITS_I == 2'h2)
                  DRIVE_STRENGTH_O <= ADDR_I[`LCM_EMR_DS_MSB:`LCM_EMR_DS_LSB];
                else
                  CMD_ILLEGAL_O <= 1'b1;
                wait_ff <= MRD_CLKS[3:0] - 4'h1;
                BUSY_O <= (MRD_CLKS > 1);
              end
              `LCM_CMD_REFRESH:
              begin
                // internal precharge: all banks closed afterwards
                BANK_OPEN_O <= {NBANK{1'b0}};
                wait_ff <= RFC_CLKS[3:0] - 4'h1;
                BUSY_O <= (RFC_CLKS > 1);
              end
              `LCM_CMD_PRECHARGE:
              begin
                if (ADDR_I[`LCM_AP_BIT])
                  BANK_OPEN_O <= {NBANK{1'b0}};
                else
                  BANK_OPEN_O <= BANK_OPEN_O & ~bank_onehot(BANK_SELECT_BITS_I);
              end
              `LCM_CMD_ACTIVATE:
                BANK_OPEN_O <= BANK_OPEN_O | bank_onehot(BANK_SELECT_BITS_I);
              `LCM_CMD_READ, `LCM_CMD_WRITE:
              begin
                // new column command overrides any running burst
                BURST_ACTIVE_O <= MODE_VALID_O;
                CMD_ILLEGAL_O <= ~MODE_VALID_O;
                beat_ff <= burst_beats(BURST_LEN_CODE_O);
                idx_ff <= 9'h000;
                start_ff <= ADDR_I[7:0];
                ap_ff <= ADDR_I[`LCM_AP_BIT];
                is_wr_ff <= (cmd == `LCM_CMD_WRITE);
                ARR_BANK_O <= BANK_SELECT_BITS_I;
              end
              `LCM_CMD_TERMINATE:
                BURST_ACTIVE_O <= 1'b0;
              default:
              begin
              end
            endcase
          end
        end
        ST_SELF_REFRESH:
        begin
          if (CKE_I && nop_or_desel)
          begin
            wait_ff <= XSR_USE[3:0];
            BUSY_O <= 1'b1;
            pstate_ff <= ST_EXIT;
          end
        end
        ST_POWER_DOWN, ST_DEEP_POWER_DOWN:
        begin
          if (CKE_I && nop_or_desel)
          begin
            wait_ff <= XP_CLKS[3:0];
            BUSY_O <= (XP_CLKS > 0);
            pstate_ff <= ST_EXIT;
            // deep power-down loses the mode contents
            if (pstate_ff == ST_DEEP_POWER_DOWN)
            begin
              MODE_VALID_O <= 1'b0;
              BANK_OPEN_O <= {NBANK{1'b0}};
            end
          end
        end
        ST_EXIT:
        begin
          if (wait_ff == 4'h1)
            pstate_ff <= ST_IDLE;
        end
        default:
          pstate_ff <= ST_IDLE;
      endcase
      POWER_STATE_O <= pstate_ff;
    end
  end
endmodule // lcm_top
`default_nettype wire

/* test/lcm_top_asserts.sv */
// concurrent checks on the command decoder ports
`timescale 1ns/100ps
`default_nettype none
`include "lcm_regs.vh"
module lcm_top_asserts #(
  parameter NBANK = 4
)(
  // clock, reset, command port
  input wire CLOCK_I,
  input wire RST_N_I,
  input wire CKE_I,
  input wire CS_N_I,
  input wire RAS_N_I,
  input wire CAS_N_I,
  input wire WE_N_I,
  input wire [1:0] BANK_SELECT_BITS_I,
  input wire [10:0] ADDR_I,
  // status
  input wire [NBANK-1:0] BANK_OPEN_O,
  input wire MODE_VALID_O,
  input wire [2:0] BURST_LEN_CODE_O,
  input wire [2:0] READ_LATENCY_O,
  input wire [2:0] DRIVE_STRENGTH_O,
  input wire BUSY_O,
  input wire CMD_ILLEGAL_O,
  input wire [2:0] POWER_STATE_O
);
  // ==========
  // helpers
  reg cke_q_ff; // enable at the previous edge, cleared in reset like the decoder's
  wire [3:0] cmd = {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I};
  // a command counts only while awake, idle and not waiting
  wire take = CKE_I && cke_q_ff && !CS_N_I && !BUSY_O && POWER_STATE_O == 3'h0;
  wire entry = cke_q_ff && !CKE_I && !BUSY_O && POWER_STATE_O == 3'h0;
  wire [NBANK-1:0] one_hot = {{(NBANK-1){1'b0}}, 1'b1} << BANK_SELECT_BITS_I;
  always @(posedge CLOCK_I)
  begin
    cke_q_ff <= RST_N_I & CKE_I;
  end
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  // ==========
  // assertions
  a_mode_fields:
  assert property (take && cmd == `LCM_CMD_LOAD && BANK_SELECT_BITS_I == 2'h0 |=> MODE_VALID_O
    && BURST_LEN_CODE_O == $past(ADDR_I[2:0]) && READ_LATENCY_O == $past(ADDR_I[6:4]))
    else $error("mode load fields wrong");
  a_ext_drive:
  assert property (take && cmd == `LCM_CMD_LOAD && BANK_SELECT_BITS_I == 2'h2
    |=> DRIVE_STRENGTH_O == $past(ADDR_I[7:5])) else $error("drive strength wrong");
  a_load_wait:
  assert property (take && cmd == `LCM_CMD_LOAD && BANK_SELECT_BITS_I == 2'h0
    |=> BUSY_O ##1 !BUSY_O) else $error("load wait wrong");
  a_load_bad_bank:
  assert property (take && cmd == `LCM_CMD_LOAD && BANK_SELECT_BITS_I[0] |=> CMD_ILLEGAL_O)
    else $error("odd bank load not flagged");
  a_col_first:
  assert property (take && !MODE_VALID_O && (cmd == `LCM_CMD_READ || cmd == `LCM_CMD_WRITE)
    |=> CMD_ILLEGAL_O) else $error("column before mode not flagged");
  a_bank_open:
  assert property (take && MODE_VALID_O && cmd == `LCM_CMD_ACTIVATE
    |=> BANK_OPEN_O == ($past(BANK_OPEN_O) | $past(one_hot))) else $error("bank open wrong");
  a_pre_all:
  assert property (take && cmd == `LCM_CMD_PRECHARGE && ADDR_I[10] |=> BANK_OPEN_O == 0)
    else $error("precharge all wrong");
  a_sr_entry:
  assert property (entry && cmd == `LCM_CMD_REFRESH |-> ##2 POWER_STATE_O == 3'h1)
    else $error("self refresh entry wrong");
  a_dpd_entry:
  assert property (entry && cmd == `LCM_CMD_TERMINATE |-> ##2 POWER_STATE_O == 3'h3)
    else $error("deep power-down entry wrong");
  a_pd_exit:
  assert property ((POWER_STATE_O == 3'h1 || POWER_STATE_O == 3'h2) && CKE_I && !cke_q_ff
    && cmd == `LCM_CMD_NOP |-> ##[1:4] POWER_STATE_O == 3'h0) else $error("exit wrong");
  // ==========
  // covers
  c_write: cover property (take && cmd == `LCM_CMD_WRITE);
  c_self_ref: cover property (POWER_STATE_O == 3'h1);
  c_illegal: cover property (CMD_ILLEGAL_O);
endmodule // lcm_top_asserts
`default_nettype wire

/* test/lcm_ctrl_model.sv */
// controller-side model driving the command and address lines
`timescale 1ns/100ps
`default_nettype none
`include "lcm_regs.vh"
module lcm_ctrl_model (
  // clock
  input wire logic clk_i,
  // command and address
  output logic cke_o,
  output logic [3:0] cmd_o,
  output logic [1:0] bank_o,
  output logic [10:0] addr_o
);
  initial
  begin
    cke_o = 1'b1;
    cmd_o = `LCM_CMD_NOP;
    bank_o = 2'h0;
    addr_o = 11'h0;
  end
  // one command for one edge, then a no-operation slot: two clocks after a load
  task issue(input logic [3:0] c, input logic [1:0] b, input logic [10:0] a, input logic k);
    @(posedge clk_i);
    #1;
    cke_o = k;
    cmd_o = c;
    bank_o = b;
    addr_o = a;
    @(posedge clk_i);
    #1;
    cmd_o = `LCM_CMD_NOP;
    bank_o = ~b; // released lines show the inverse, not the old value
    addr_o = ~a;
  endtask
endmodule // lcm_ctrl_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the command decoder and masked write path
`timescale 1ns/100ps
`default_nettype none
`include "lcm_regs.vh"
module tb;
  // ==========
  // wiring and bench state
  logic clk, rst_n, wv, ar, stall, ok;
  logic [31:0] wd;
  logic [3:0] wm;
  wire cke, wr_rdy, a_v, mv, b_act, busy, ill, bint;
  wire [3:0] cmd, a_be, b_open;
  wire [1:0] ba, a_bank;
  wire [10:0] ad;
  wire [31:0] a_d;
  wire [7:0] a_col;
  wire [2:0] bl, cl, ds, pst;
  integer errors = 0, n_checks = 0, seed = 48945, i, n, r;
  logic [35:0] exp_q[$]; // expected {data, byte enables}
  logic [2:0] codes [0:4] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
  logic [3:0] pcmd [0:2] = '{`LCM_CMD_REFRESH, `LCM_CMD_NOP, `LCM_CMD_TERMINATE};
  // write recovery plus precharge, each rounded up to a clock, never under three
  localparam int DAL_RAW = (15 + 99) / 100 + (15 + 99) / 100;
  localparam int DAL_CLKS = DAL_RAW < 3 ? 3 : DAL_RAW;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  lcm_ctrl_model i_ctl (.clk_i(clk), .cke_o(cke), .cmd_o(cmd), .bank_o(ba), .addr_o(ad));
  lcm_top i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .CKE_I(cke), .CS_N_I(cmd[3]),
    .RAS_N_I(cmd[2]), .CAS_N_I(cmd[1]), .WE_N_I(cmd[0]), .BANK_SELECT_BITS_I(ba),
    .ADDR_I(ad), .WDATA_VALID_I(wv), .WDATA_I(wd), .WRITE_BYTE_MASK_I(wm),
    .WDATA_READY_O(wr_rdy), .ARR_VALID_O(a_v), .ARR_READY_I(ar), .ARR_DATA_O(a_d),
    .ARR_BYTE_EN_O(a_be), .ARR_BANK_O(a_bank), .ARR_COL_O(a_col), .BANK_OPEN_O(b_open),
    .MODE_VALID_O(mv), .BURST_LEN_CODE_O(bl), .BURST_INTERLEAVED_O(bint),
    .READ_LATENCY_O(cl), .DRIVE_STRENGTH_O(ds), .BURST_ACTIVE_O(b_act), .BUSY_O(busy),
    .CMD_ILLEGAL_O(ill), .POWER_STATE_O(pst));
  // ==========
  // compare, report and close
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %0t status got %h exp %h", $time, g, e);
    end
  endtask
  task chk_beat(input logic [35:0] g, input logic [35:0] e);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %0t beat got %h exp %h", $time, g, e);
    end
  endtask
  // bounded wait for the decoder to settle back to idle
  task wait_idle;
    for (i = 0; i < 20 && !(busy === 1'b0 && pst === 3'h0); i++)
    begin
      @(posedge clk);
      #1;
    end
    chk({31'h0, busy === 1'b0 && pst === 3'h0}, 32'h1);
    if (errors != 0)
      complete_run();
  endtask
  // one beat offered for up to three edges; only a taken beat is expected
  task push;
    ok = 1'b0;
    wv = 1'b1;
    wd = $random(seed);
    wm = 4'($random(seed));
    for (r = 0; r < 3 && !ok; r++)
    begin
      @(negedge clk);
      ok = wr_rdy;
      @(posedge clk);
      #1;
    end
    if (ok)
      exp_q.push_back({wd, ~wm});
  endtask
  // drain side: random stalls, every drained beat compared in order
  always @(negedge clk)
    if (a_v === 1'b1 && ar === 1'b1)
      chk_beat({a_d, a_be}, exp_q.size() > 0 ? exp_q.pop_front() : 36'h0);
  always @(posedge clk)
  begin
    #1;
    ar = !stall && ($random(seed) & 1);
  end
  // ==========
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    wv = 1'b0;
    wd = 32'h0;
    wm = 4'h0;
    ar = 1'b0;
    stall = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({mv, wr_rdy, a_v}, 32'h2);
    i_ctl.issue(`LCM_CMD_NOP, 2'h0, 11'h0, 1'b1);
    i_ctl.issue(`LCM_CMD_READ, 2'h0, 11'h0, 1'b1);
    chk(32'(ill), 32'h1);
    $display("reset and early column done");
    i_ctl.issue(`LCM_CMD_PRECHARGE, 2'h0, 11'h400, 1'b1);
    for (n = 0; n < 2; n++)
      i_ctl.issue(`LCM_CMD_REFRESH, 2'h0, 11'h0, 1'b1);
    for (n = 0; n < 5; n++)
    begin
      i_ctl.issue(`LCM_CMD_LOAD, 2'h0, {4'h0, 3'(2 + n % 2), n[0], codes[n]}, 1'b1);
      chk({mv, bint, cl, bl}, {24'h0, 1'b1, n[0], 3'(2 + n % 2), codes[n]});
    end
    for (n = 0; n < 4; n++)
    begin
      i_ctl.issue(`LCM_CMD_LOAD, 2'h2, {3'h0, 3'(n), 5'h0}, 1'b1);
      chk(32'(ds), n);
    end
    i_ctl.issue(`LCM_CMD_LOAD, 2'h1, 11'h0, 1'b1);
    chk({ill, bl}, 32'hc);
    $display("mode loads done");
    for (n = 0; n < 4; n++)
    begin
      i_ctl.issue(`LCM_CMD_ACTIVATE, 2'(n), 11'h0, 1'b1);
      chk(32'(b_open), (2 << n) - 1);
    end
    i_ctl.issue(`LCM_CMD_PRECHARGE, 2'h1, 11'h0, 1'b1);
    chk(32'(b_open), 32'hd);
    i_ctl.issue(`LCM_CMD_PRECHARGE, 2'($random(seed)), 11'h400, 1'b1);
    chk(32'(b_open), 32'h0);
    i_ctl.issue(`LCM_CMD_ACTIVATE, 2'h2, 11'h0, 1'b1);
    i_ctl.issue(`LCM_CMD_WRITE, 2'h2, {3'h0, 8'($random(seed))}, 1'b1);
    chk(32'(a_bank), 32'h2);
    n = 0;
    for (i = 0; i < 9; i++)
    begin
      push();
      n = n + ok;
    end
    chk(n, 8);
    stall = 1'b0;
    for (i = 0; i < 40 && n < 16; i++)
    begin
      push();
      n = n + ok;
    end
    wv = 1'b0;
    chk({n, b_act}, 32'h20);
    for (i = 0; i < 60 && exp_q.size() > 0; i++)
      @(posedge clk);
    chk(exp_q.size(), 0);
    $display("fill and drain done");
    i_ctl.issue(`LCM_CMD_WRITE, 2'h2, 11'h01f, 1'b1);
    push();
    push();
    wv = 1'b0;
    chk(32'(a_col), 32'h10);
    i_ctl.issue(`LCM_CMD_TERMINATE, 2'h0, 11'h0, 1'b1);
    chk(32'(b_act), 32'h0);
    repeat (DAL_CLKS) @(posedge clk);
    i_ctl.issue(`LCM_CMD_PRECHARGE, 2'h0, 11'h400, 1'b1);
    $display("terminate done");
    for (n = 0; n < 3; n++)
    begin
      i_ctl.issue(pcmd[n], 2'h0, 11'h0, 1'b0);
      // the power state output trails the internal state by one clock
      @(posedge clk);
      #1;
      chk(32'(pst), n + 1);
      i_ctl.issue(`LCM_CMD_NOP, 2'h0, 11'h0, 1'b1);
      wait_idle();
    end
    chk(32'(mv), 32'h0);
    $display("power states done");
    for (i = 0; i < 60 && exp_q.size() > 0; i++)
      @(posedge clk);
    chk(exp_q.size(), 0);
    complete_run();
  end
endmodule // tb
bind lcm_top lcm_top_asserts #(.NBANK(NBANK)) i_chk (.CLOCK_I, .RST_N_I, .CKE_I, .CS_N_I,
  .RAS_N_I, .CAS_N_I, .WE_N_I, .BANK_SELECT_BITS_I, .ADDR_I, .BANK_OPEN_O, .MODE_VALID_O,
  .BURST_LEN_CODE_O, .READ_LATENCY_O, .DRIVE_STRENGTH_O, .BUSY_O, .CMD_ILLEGAL_O,
  .POWER_STATE_O);
`default_nettype wire
